//--- rtl/hri_top.sv
/*
 Hall rotation angle and interval user interface: serial register
 slave, degree filter, movement flags, zeroing and event output.
 Assumes an open-drain two-wire host bus and a front end that strobes
 plate readings on the system clock.
*/
// Notes on behaviour
// R1: Bit 7 of flags shows magnet moved
// R2: Bit 6 of flags gives movement direction
// R3: Bit 1 set while movement count negative
// R4: Bit 0 set while relative angle negative
// R5: Flags follow even the smallest angle change
// R6: Filtered angle 0..359 as two bytes
// R7: Interval count is one 8-bit RW register
// R8: Raw degree output as two bytes
// R9: Per-cycle angle change stored, 0..180 degrees
// R10: Interval size 3..180 degrees, host keeps minimum
// R11: Host can zero wheel at current position
// R12: Event each time interval count changes
// R13: Setting inverts reported rotation direction
// R14: Wheel offset added before interval boundaries
// R15: Sine and cosine phase constants correct angle
// R16: Host tunes filter coefficient to noise
// R17: Host enables automatic tuning for drift; no tuning logic here, the tuning registers are only stored and read back
// R18: Host enables user interface and calibration
// R19: Zero bit self-clears after zeroing
// R20: One degree hysteresis toward rotation direction
// R21: Interval count is corrected angle over size
`timescale 1ns/1ps
`default_nettype none
module hri_top
	import hri_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = hri_pkg::I2C_ADDR_DFLT
)
(
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_N_O,
	input wire logic SAMPLE_VALID_I,
	input wire logic signed [hri_pkg::PLATE_W-1:0] PLATE_A_I,
	input wire logic signed [hri_pkg::PLATE_W-1:0] PLATE_B_I,
	output logic EVENT_O
);
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic scl_m_ff, scl_s_ff, scl_d_ff, sda_m_ff, sda_s_ff, sda_d_ff;
	logic i2c_start, i2c_stop, scl_rise, scl_fall;
	hri_i2c_st_t st_ff;
	logic [3:0] cnt_ff;
	logic [7:0] sh_ff, tx_ff, ptr_ff, wa_ff, wd_ff, rd_data, rd_next;
	logic nack_ff, oe_n_ff, wr_ff, sda_o_ff;
	logic [7:0] ui_ff, sens_ff, tune_a_ff, tune_b_ff, dirset_ff;
	logic [7:0] sin_ff, cos_ff, beta_ff, wake_ff, isize_ff, delta_ff;
	logic [15:0] ofs_ff, raw_ff;
	logic [8:0] filt_ff, zero_ff, nf, rep, pos, ofs_m;
	logic signed [10:0] d0, dw, step, nsum;
	logic signed [19:0] prod;
	logic signed [15:0] mv_cnt_ff;
	logic moved_ff, dir_ff, rel_neg_ff, upd_ff, event_ff;
	logic [7:0] flags;
	hri_link_if lnk();

	always_ff @(posedge CLOCK_I or negedge RSTN_I)
		if (!RSTN_I)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	assign rst_n = rst_sync_ff[1];

	// Bus pins pass two flops, a third copy finds edges
	always_ff @(posedge CLOCK_I or negedge rst_n)
		if (!rst_n)
		begin
			scl_m_ff <= 1'b1;
			scl_s_ff <= 1'b1;
			scl_d_ff <= 1'b1;
			sda_m_ff <= 1'b1;
			sda_s_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end
		else
		begin
			scl_m_ff <= SCL_I;
			scl_s_ff <= scl_m_ff;
			scl_d_ff <= scl_s_ff;
			sda_m_ff <= SDA_I;
			sda_s_ff <= sda_m_ff;
			sda_d_ff <= sda_s_ff;
		end

	assign i2c_start = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
	assign i2c_stop = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;
	assign scl_rise = scl_s_ff && !scl_d_ff;
	assign scl_fall = !scl_s_ff && scl_d_ff;

	function automatic logic [7:0] reg_read(input logic [7:0] a);
		case (a)
			ADDR_FLAGS: return flags;
			ADDR_FILT_LO: return rep[7:0]; // [R6]
			ADDR_FILT_HI: return {7'h00, rep[8]};
			ADDR_IVAL: return lnk.ival_count;
			ADDR_UI_SET: return ui_ff;
			ADDR_SENS_SET: return sens_ff;
			ADDR_TUNE_A: return tune_a_ff;
			ADDR_TUNE_B: return tune_b_ff;
			ADDR_DIR_SET: return dirset_ff;
			ADDR_SIN_K: return sin_ff;
			ADDR_COS_K: return cos_ff;
			ADDR_BETA: return beta_ff;
			ADDR_WAKE: return wake_ff;
			ADDR_ISIZE: return isize_ff;
			ADDR_OFS_LO: return ofs_ff[7:0];
			ADDR_OFS_HI: return ofs_ff[15:8];
			ADDR_RAW_LO: return raw_ff[7:0]; // [R8]
			ADDR_RAW_HI: return raw_ff[15:8];
			ADDR_DELTA: return delta_ff;
			default: return 8'h00;
		endcase
	endfunction : reg_read

	// A process, so the mux follows registers behind the pointer
	always_comb
	begin
		rd_data = reg_read(ptr_ff);
		rd_next = reg_read(ptr_ff + 8'h01);
	end

	// Serial slave: pointer byte, then data with auto increment
	always_ff @(posedge CLOCK_I or negedge rst_n)
		if (!rst_n)
		begin
			st_ff <= I2C_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			tx_ff <= 8'h00;
			ptr_ff <= 8'h00;
			nack_ff <= 1'b0;
			oe_n_ff <= 1'b1;
			wr_ff <= 1'b0;
			wa_ff <= 8'h00;
			wd_ff <= 8'h00;
		end
		else
		begin
			wr_ff <= 1'b0;
			if (i2c_start)
			begin
				st_ff <= I2C_ADDR;
				cnt_ff <= 4'h0;
				oe_n_ff <= 1'b1;
			end
			else if (i2c_stop)
			begin
				st_ff <= I2C_IDLE;
				oe_n_ff <= 1'b1;
			end
			else if (scl_rise)
			begin
				if (st_ff == I2C_ACKR)
					nack_ff <= sda_s_ff;
				else if (st_ff == I2C_ADDR || st_ff == I2C_REG
					|| st_ff == I2C_WDATA)
				begin
					sh_ff <= {sh_ff[6:0], sda_s_ff};
					cnt_ff <= cnt_ff + 4'h1;
				end
				else if (st_ff == I2C_RDATA)
					cnt_ff <= cnt_ff + 4'h1;
			end
			else if (scl_fall)
			begin
				case (st_ff)
					I2C_ADDR:
						if (cnt_ff == BYTE_BITS)
						begin
							if (sh_ff[7:1] == DEV_ADDR)
							begin
								st_ff <= I2C_ACKA;
								oe_n_ff <= 1'b0;
							end
							else
								st_ff <= I2C_IDLE;
						end
					I2C_ACKA:
					begin
						cnt_ff <= 4'h0;
						if (sh_ff[0])
						begin
							st_ff <= I2C_RDATA;
							tx_ff <= rd_data;
							oe_n_ff <= rd_data[7];
						end
						else
						begin
							st_ff <= I2C_REG;
							oe_n_ff <= 1'b1;
						end
					end
					I2C_REG:
						if (cnt_ff == BYTE_BITS)
						begin
							ptr_ff <= sh_ff;
							st_ff <= I2C_ACKW;
							oe_n_ff <= 1'b0;
						end
					I2C_WDATA:
						if (cnt_ff == BYTE_BITS)
						begin
							wr_ff <= 1'b1;
							wa_ff <= ptr_ff;
							wd_ff <= sh_ff;
							ptr_ff <= ptr_ff + 8'h01;
							st_ff <= I2C_ACKW;
							oe_n_ff <= 1'b0;
						end
					I2C_ACKW:
					begin
						st_ff <= I2C_WDATA;
						cnt_ff <= 4'h0;
						oe_n_ff <= 1'b1;
					end
					I2C_RDATA:
						if (cnt_ff == BYTE_BITS)
						begin
							st_ff <= I2C_ACKR;
							oe_n_ff <= 1'b1;
						end
						else
						begin
							tx_ff <= {tx_ff[6:0], 1'b0};
							oe_n_ff <= tx_ff[6];
						end
					I2C_ACKR:
						if (nack_ff)
							st_ff <= I2C_IDLE;
						else
						begin
							ptr_ff <= ptr_ff + 8'h01;
							tx_ff <= rd_next;
							oe_n_ff <= rd_next[7];
							cnt_ff <= 4'h0;
							st_ff <= I2C_RDATA;
						end
					default:
						st_ff <= I2C_IDLE;
				endcase
			end
		end

	// Settings store; zero bit drops one cycle after it is seen
	always_ff @(posedge CLOCK_I or negedge rst_n)
		if (!rst_n)
		begin
			ui_ff <= UI_SET_RST;
			sens_ff <= 8'h00;
			tune_a_ff <= 8'h00;
			tune_b_ff <= 8'h00;
			dirset_ff <= 8'h00;
			sin_ff <= 8'h00;
			cos_ff <= COS_K_RST;
			beta_ff <= 8'h00;
			wake_ff <= 8'h00;
			isize_ff <= ISIZE_RST;
			ofs_ff <= 16'h0000;
		end
		else if (wr_ff)
		begin
			case (wa_ff)
				ADDR_UI_SET: ui_ff <= wd_ff;
				ADDR_SENS_SET: sens_ff <= wd_ff;
				ADDR_TUNE_A: tune_a_ff <= wd_ff;
				ADDR_TUNE_B: tune_b_ff <= wd_ff;
				ADDR_DIR_SET: dirset_ff <= wd_ff; // [R13]
				ADDR_SIN_K: sin_ff <= wd_ff; // [R15]
				ADDR_COS_K: cos_ff <= wd_ff;
				ADDR_BETA: beta_ff <= wd_ff;
				ADDR_WAKE: wake_ff <= wd_ff;
				ADDR_ISIZE: isize_ff <= wd_ff; // [R10]
				ADDR_OFS_LO: ofs_ff[7:0] <= wd_ff; // [R14]
				ADDR_OFS_HI: ofs_ff[15:8] <= wd_ff;
				default: ui_ff <= ui_ff;
			endcase
		end
		else if (ui_ff[UI_ZERO_BIT])
			ui_ff[UI_ZERO_BIT] <= 1'b0; // [R19]

	// Raw and delta outputs: a new sample beats a host write
	always_ff @(posedge CLOCK_I or negedge rst_n)
		if (!rst_n)
		begin
			raw_ff <= 16'h0000;
			delta_ff <= 8'h00;
		end
		else
		begin
			if (lnk.ang_done && !ui_ff[UI_WHEEL_DIS_BIT])
				raw_ff <= {7'h00, lnk.raw_deg}; // [R8]
			else if (wr_ff && wa_ff == ADDR_RAW_LO)
				raw_ff[7:0] <= wd_ff;
			else if (wr_ff && wa_ff == ADDR_RAW_HI)
				raw_ff[15:8] <= wd_ff;
			// Taken with the filter step, before the filter moves on
			if (lnk.ang_done && !ui_ff[UI_WHEEL_DIS_BIT]
				&& !ui_ff[UI_ZERO_BIT])
				delta_ff <= step[10] ? 8'(-step) : step[7:0]; // [R9]
			else if (wr_ff && wa_ff == ADDR_DELTA)
				delta_ff <= wd_ff;
		end

	// Filter step on the shortest way round the circle
	always_comb
	begin
		d0 = $signed({2'b00, lnk.raw_deg}) - $signed({2'b00, filt_ff});
		dw = d0;
		if (d0 > DEG_FWD_MAX)
			dw = d0 - $signed(DEG_FULL);
		else if (d0 < DEG_BWD_MIN)
			dw = d0 + $signed(DEG_FULL);
		prod = 20'(dw) * 20'($signed({1'b0, beta_ff}));
		step = dw - 11'(prod >>> FILT_SH);
		nsum = $signed({2'b00, filt_ff}) + step;
		if (nsum < 0)
			nsum = nsum + $signed(DEG_FULL);
		nf = hri_wrap(nsum);
		rep = hri_wrap({2'b00, filt_ff} + DEG_FULL - {2'b00, zero_ff}); // [R11]
		ofs_m = (ofs_ff >= 16'(DEG_FULL)) ? 9'h000 : ofs_ff[8:0];
		pos = hri_wrap({2'b00, rep} + {2'b00, ofs_m}); // [R14]
	end

	// Filtered angle, movement flags and zero reference
	always_ff @(posedge CLOCK_I or negedge rst_n)
		if (!rst_n)
		begin
			filt_ff <= 9'h000;
			zero_ff <= 9'h000;
			mv_cnt_ff <= 16'sh0000;
			moved_ff <= 1'b0;
			dir_ff <= 1'b0;
			rel_neg_ff <= 1'b0;
			upd_ff <= 1'b0;
		end
		else
		begin
			upd_ff <= 1'b0;
			if (ui_ff[UI_ZERO_BIT])
			begin
				zero_ff <= filt_ff; // [R11] [R19]
				mv_cnt_ff <= 16'sh0000;
			end
			else if (lnk.ang_done && !ui_ff[UI_WHEEL_DIS_BIT])
			begin
				filt_ff <= nf;
				upd_ff <= 1'b1;
				moved_ff <= (step != 11'sh000); // [R1] [R5]
				rel_neg_ff <= step[10]; // [R4]
				mv_cnt_ff <= mv_cnt_ff + 16'(step); // [R3]
				if (step != 11'sh000)
					dir_ff <= !step[10] ^ dirset_ff[DIR_INVERT_BIT]; // [R2] [R13]
			end
		end

	always_comb
	begin
		flags = 8'h00;
		flags[FLAG_MOVED_BIT] = moved_ff; // [R1]
		flags[FLAG_DIR_BIT] = dir_ff; // [R2]
		flags[FLAG_CNT_NEG_BIT] = mv_cnt_ff[15]; // [R3]
		flags[FLAG_REL_NEG_BIT] = rel_neg_ff; // [R4]
	end

	// Event pin: touch wake mode mutes rotation events
	always_ff @(posedge CLOCK_I or negedge rst_n)
		if (!rst_n)
			event_ff <= 1'b0;
		else
			event_ff <= !ui_ff[UI_WAKE_BIT]
				&& ((lnk.ival_chg && !ui_ff[UI_IVAL_EVT_DIS_BIT]) // [R12]
				|| (upd_ff && moved_ff && !ui_ff[UI_WHEEL_EVT_DIS_BIT]));

	always_ff @(posedge CLOCK_I or negedge rst_n)
		if (!rst_n)
			sda_o_ff <= 1'b0;
		else
			sda_o_ff <= 1'b0;

	assign lnk.smp_valid = SAMPLE_VALID_I;
	assign lnk.plate_a = PLATE_A_I;
	assign lnk.plate_b = PLATE_B_I;
	assign lnk.sin_k = sin_ff;
	assign lnk.cos_k = cos_ff;
	assign lnk.ival_go = upd_ff; // [R21]
	assign lnk.ival_pos = pos;
	assign lnk.ival_size = isize_ff;
	assign lnk.ival_hold = ui_ff[UI_IVAL_DIS_BIT];
	assign lnk.ival_wr = wr_ff && (wa_ff == ADDR_IVAL); // [R7]
	assign lnk.ival_wdata = wd_ff;

	hri_angle u_angle (
		.clk_i(CLOCK_I),
		.rst_n_i(rst_n),
		.lnk(lnk.ang)
	);

	hri_interval u_interval (
		.clk_i(CLOCK_I),
		.rst_n_i(rst_n),
		.lnk(lnk.ivl)
	);

	assign SDA_O = sda_o_ff;
	assign SDA_OE_N_O = oe_n_ff;
	assign EVENT_O = event_ff;
endmodule : hri_top
`default_nettype wire

//--- rtl/hri_pkg.sv
/*
 Shared constants for the Hall rotation angle and interval block:
 register offsets, field positions, reset values, angle arithmetic.
 Assumes an 8-bit register space reached over a two-wire serial bus.
*/
package hri_pkg;
	localparam logic [7:0] ADDR_FLAGS = 8'h14;
	localparam logic [7:0] ADDR_FILT_LO = 8'h16;
	localparam logic [7:0] ADDR_FILT_HI = 8'h17;
	localparam logic [7:0] ADDR_IVAL = 8'h18;
	localparam logic [7:0] ADDR_UI_SET = 8'h70;
	localparam logic [7:0] ADDR_SENS_SET = 8'h71;
	localparam logic [7:0] ADDR_TUNE_A = 8'h72;
	localparam logic [7:0] ADDR_TUNE_B = 8'h73;
	localparam logic [7:0] ADDR_DIR_SET = 8'h78;
	localparam logic [7:0] ADDR_SIN_K = 8'h79;
	localparam logic [7:0] ADDR_COS_K = 8'h7a;
	localparam logic [7:0] ADDR_BETA = 8'h7b;
	localparam logic [7:0] ADDR_WAKE = 8'h7c;
	localparam logic [7:0] ADDR_ISIZE = 8'h7d;
	localparam logic [7:0] ADDR_OFS_LO = 8'h7e;
	localparam logic [7:0] ADDR_OFS_HI = 8'h7f;
	localparam logic [7:0] ADDR_RAW_LO = 8'h80;
	localparam logic [7:0] ADDR_RAW_HI = 8'h81;
	localparam logic [7:0] ADDR_DELTA = 8'h8e;
	localparam int FLAG_MOVED_BIT = 7;
	localparam int FLAG_DIR_BIT = 6;
	localparam int FLAG_CNT_NEG_BIT = 1;
	localparam int FLAG_REL_NEG_BIT = 0;
	localparam int UI_WAKE_BIT = 0;
	localparam int UI_IVAL_EVT_DIS_BIT = 3;
	localparam int UI_WHEEL_EVT_DIS_BIT = 4;
	localparam int UI_ZERO_BIT = 5;
	localparam int UI_IVAL_DIS_BIT = 6;
	localparam int UI_WHEEL_DIS_BIT = 7;
	localparam int DIR_INVERT_BIT = 0;
	localparam logic [7:0] UI_SET_RST = 8'h14;
	localparam logic [7:0] COS_K_RST = 8'h80;
	localparam logic [7:0] ISIZE_RST = 8'h03;
	localparam logic [7:0] IVAL_MIN = 8'h03;
	localparam logic [7:0] IVAL_MAX = 8'hb4;
	localparam logic [8:0] HYST_DEG = 9'h001;
	localparam logic [10:0] DEG_FULL = 11'h168;
	localparam logic signed [10:0] DEG_FWD_MAX = 11'sh0b3;
	localparam logic signed [10:0] DEG_BWD_MIN = -11'sh0b4;
	localparam int PLATE_W = 12;
	localparam int PH_SH = 7;
	localparam int FILT_SH = 8;
	localparam int ZFRAC = 6;
	localparam logic signed [15:0] Z_HALF = 16'sh2d00;
	localparam logic signed [15:0] Z_RND = 16'sh0020;
	localparam logic [3:0] CORDIC_N = 4'ha;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [6:0] I2C_ADDR_DFLT = 7'h44;

	typedef enum logic [2:0] {
		I2C_IDLE = 3'b000,
		I2C_ADDR = 3'b001,
		I2C_ACKA = 3'b010,
		I2C_REG = 3'b011,
		I2C_WDATA = 3'b100,
		I2C_ACKW = 3'b101,
		I2C_RDATA = 3'b110,
		I2C_ACKR = 3'b111
	} hri_i2c_st_t;

	function automatic logic signed [15:0] hri_atan(input logic [3:0] i);
		case (i)
			4'h0: return 16'sh0b40;
			4'h1: return 16'sh06a4;
			4'h2: return 16'sh0382;
			4'h3: return 16'sh01c8;
			4'h4: return 16'sh00e5;
			4'h5: return 16'sh0073;
			4'h6: return 16'sh0039;
			4'h7: return 16'sh001d;
			4'h8: return 16'sh000e;
			4'h9: return 16'sh0007;
			default: return 16'sh0000;
		endcase
	endfunction : hri_atan

	function automatic logic [8:0] hri_wrap(input logic [10:0] v);
		return (v >= DEG_FULL) ? 9'(v - DEG_FULL) : v[8:0];
	endfunction : hri_wrap
endpackage : hri_pkg

//--- rtl/hri_link_if.sv
/*
 Carrier between the top and its angle and interval units.
 Assumes all three run on the one system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface hri_link_if;
	import hri_pkg::*;
	logic smp_valid;
	logic signed [PLATE_W-1:0] plate_a, plate_b;
	logic [7:0] sin_k, cos_k;
	logic ang_done;
	logic [8:0] raw_deg;
	logic ival_go, ival_hold, ival_wr, ival_chg;
	logic [8:0] ival_pos;
	logic [7:0] ival_size, ival_wdata, ival_count;
	modport ang(input smp_valid, plate_a, plate_b, sin_k, cos_k,
		output ang_done, raw_deg);
	modport ivl(input ival_go, ival_hold, ival_wr, ival_pos, ival_size,
		ival_wdata, output ival_chg, ival_count);
endinterface : hri_link_if
`default_nettype wire

//--- rtl/hri_angle.sv
/*
 Phase-corrected angle from the two Hall plate readings, by CORDIC.
 Assumes one plate pair per valid strobe, strobes spaced over 12 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module hri_angle
	import hri_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	hri_link_if.ang lnk
);
	localparam int AW = 22;
	logic signed [AW-1:0] x_ff, y_ff, pa, xc, yc;
	logic signed [15:0] z_ff, zs;
	logic signed [10:0] d11;
	logic [3:0] it_ff;
	logic busy_ff, done_ff;
	logic [8:0] deg_ff;

	always_comb
	begin
		pa = AW'(lnk.plate_a);
		xc = (pa * AW'($signed({1'b0, lnk.cos_k}))) >>> PH_SH;
		yc = AW'(lnk.plate_b) - ((pa * AW'($signed(lnk.sin_k))) >>> PH_SH);
		zs = (z_ff + Z_RND) >>> ZFRAC;
		d11 = 11'(zs);
		if (d11 < 0)
			d11 = d11 + $signed(DEG_FULL);
		else if (d11 >= $signed(DEG_FULL))
			d11 = d11 - $signed(DEG_FULL);
	end

	// Vectoring: drive y to zero, sum rotations in z [R15]
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			x_ff <= '0;
			y_ff <= '0;
			z_ff <= '0;
			it_ff <= 4'h0;
			busy_ff <= 1'b0;
		end
		else if (!busy_ff && lnk.smp_valid)
		begin
			x_ff <= xc[AW-1] ? -xc : xc;
			y_ff <= xc[AW-1] ? -yc : yc;
			z_ff <= xc[AW-1] ? Z_HALF : 16'sh0000;
			it_ff <= 4'h0;
			busy_ff <= 1'b1;
		end
		else if (busy_ff)
		begin
			if (it_ff == CORDIC_N)
				busy_ff <= 1'b0;
			else
			begin
				x_ff <= y_ff[AW-1] ? x_ff - (y_ff >>> it_ff) : x_ff + (y_ff >>> it_ff);
				y_ff <= y_ff[AW-1] ? y_ff + (x_ff >>> it_ff) : y_ff - (x_ff >>> it_ff);
				z_ff <= y_ff[AW-1] ? z_ff - hri_atan(it_ff) : z_ff + hri_atan(it_ff);
				it_ff <= it_ff + 4'h1;
			end
		end

	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			done_ff <= 1'b0;
			deg_ff <= 9'h000;
		end
		else
		begin
			done_ff <= busy_ff && (it_ff == CORDIC_N);
			if (busy_ff && (it_ff == CORDIC_N))
				deg_ff <= d11[8:0];
		end

	assign lnk.ang_done = done_ff;
	assign lnk.raw_deg = deg_ff;
endmodule : hri_angle
`default_nettype wire

//--- rtl/hri_interval.sv
/*
 Interval counter: divides the corrected angle by the interval size.
 Assumes a new position arrives far less often than every 121 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module hri_interval
	import hri_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	hri_link_if.ivl lnk
);
	logic [8:0] rem_ff, size9;
	logic [7:0] q_ff, count_ff;
	logic busy_ff, chg_ff, done;

	always_comb
	begin
		size9 = {1'b0, lnk.ival_size};
		if (lnk.ival_size < IVAL_MIN)
			size9 = {1'b0, IVAL_MIN};
		else if (lnk.ival_size > IVAL_MAX)
			size9 = {1'b0, IVAL_MAX};
		done = busy_ff && (rem_ff < size9);
	end

	// Repeated subtraction keeps quotient and remainder [R21] [R10]
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			rem_ff <= 9'h000;
			q_ff <= 8'h00;
			busy_ff <= 1'b0;
		end
		else if (busy_ff)
		begin
			if (!done)
			begin
				rem_ff <= rem_ff - size9;
				q_ff <= q_ff + 8'h01;
			end
			else
				busy_ff <= 1'b0;
		end
		else if (lnk.ival_go)
		begin
			rem_ff <= lnk.ival_pos;
			q_ff <= 8'h00;
			busy_ff <= 1'b1;
		end

	// Upward change only one degree past the edge [R20]
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			count_ff <= 8'h00;
			chg_ff <= 1'b0;
		end
		else
		begin
			chg_ff <= 1'b0;
			if (lnk.ival_wr)
				count_ff <= lnk.ival_wdata; // [R7]
			else if (done && !lnk.ival_hold && (q_ff != count_ff)
				&& ((q_ff < count_ff) || (rem_ff >= HYST_DEG))) // [R20]
			begin
				count_ff <= q_ff;
				chg_ff <= 1'b1; // [R12]
			end
		end

	assign lnk.ival_count = count_ff;
	assign lnk.ival_chg = chg_ff;
endmodule : hri_interval
`default_nettype wire

//--- testbench/hri_rot_chk.sv
/*
 Port checker for the rotation block: bus drive timing, event pulses.
 Assumes SCL and SDA are sampled by the system clock through syncs.
*/
`timescale 1ns/1ps
`default_nettype none
module hri_rot_chk
(
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	input wire logic SCL_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_N_O,
	input wire logic SAMPLE_VALID_I,
	input wire logic EVENT_O
);
	logic [7:0] since_ff;
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RSTN_I);
	// Cycles since the last plate strobe, saturating
	always_ff @(posedge CLOCK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			since_ff <= 8'hff;
		else if (SAMPLE_VALID_I)
			since_ff <= 8'h00;
		else if (since_ff != 8'hff)
			since_ff <= since_ff + 8'h01;
	end
	sda_open_drain_a: assert property (!SDA_O)
		else $error("SDA driven high");
	sda_change_win_a: assert property ($changed(SDA_OE_N_O) |->
		!SCL_I && !$past(SCL_I, 2))
		else $error("SDA drive changed outside the low phase");
	sda_hold_high_a: assert property (
		SCL_I && $past(SCL_I) |-> $stable(SDA_OE_N_O))
		else $error("SDA drive changed while SCL high");
	sda_rst_idle_a: assert property ($rose(RSTN_I) |-> SDA_OE_N_O [*6])
		else $error("SDA driven just after reset");
	evt_one_cycle_a: assert property (EVENT_O |=> !EVENT_O)
		else $error("Event longer than one cycle");
	evt_not_early_a: assert property (EVENT_O |-> since_ff >= 8'h0d)
		else $error("Event too soon after a strobe");
	evt_after_smp_a: assert property (SAMPLE_VALID_I |=> !EVENT_O [*8])
		else $error("Event right after a strobe");
	evt_rst_quiet_a: assert property ($rose(RSTN_I) |-> !EVENT_O [*4])
		else $error("Event just after reset");
endmodule : hri_rot_chk
bind hri_top hri_rot_chk u_chk (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I),
	.SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O),
	.SAMPLE_VALID_I(SAMPLE_VALID_I), .EVENT_O(EVENT_O));
`default_nettype wire

//--- testbench/hri_host_model.sv
/*
 Host model: master on the two-wire register bus, 48 ns bit period.
 Assumes the bench resolves SDA with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module hri_host_model
#(
	parameter logic [6:0] DEV = 7'h44
)
(
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	output logic [7:0] nack_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		rd_valid_o = 1'b0;
		rd_data_o = 8'h00;
		nack_o = 8'h00;
	end
	// One quarter of the bit period
	task automatic pin(input logic s, input logic d);
		scl_o = s;
		sda_o = d;
		repeat (3) @(posedge clk_i);
		#1;
	endtask : pin
	task automatic bit_io(input logic b, output logic r);
		pin(1'b0, b);
		pin(1'b1, b);
		r = sda_i;
		pin(1'b1, b);
		pin(1'b0, b);
	endtask : bit_io
	task automatic start();
		pin(scl_o, 1'b1);
		pin(1'b1, 1'b1);
		pin(1'b1, 1'b0);
		pin(1'b0, 1'b0);
	endtask : start
	task automatic stop();
		pin(1'b0, 1'b0);
		pin(1'b1, 1'b0);
		pin(1'b1, 1'b1);
	endtask : stop
	task automatic put(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		if (r !== 1'b0)
			nack_o++;
	endtask : put
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		start();
		put({DEV, 1'b0});
		put(a);
		put(d);
		stop();
	endtask : write
	task automatic read(input logic [7:0] a);
		logic [7:0] v;
		logic r;
		start();
		put({DEV, 1'b0});
		put(a);
		start();
		put({DEV, 1'b1});
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, v[i]);
		// Master ends the read with a NACK
		bit_io(1'b1, r);
		stop();
		rd_data_o = v;
		rd_valid_o = 1'b1;
		@(posedge clk_i);
		#1;
		rd_valid_o = 1'b0;
	endtask : read
endmodule : hri_host_model
`default_nettype wire

//--- testbench/hall_rotation_angle_interval_ui_tb.sv
/*
 Bench: host model reads and writes registers while plate pairs are
 strobed in; read results are compared against a queue of notes.
 Assumes the package, carrier and design are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module hall_rotation_angle_interval_ui_tb;
	import hri_pkg::*;
	logic clk, rst_n, scl, host_sda, smp_v, evt, sda_drv, sda_oe_n, rd_v;
	logic signed [PLATE_W-1:0] pa, pb;
	logic [7:0] rd_d, nack, r;
	logic [7:0] rw_a [3] = '{ADDR_SIN_K, ADDR_WAKE, ADDR_OFS_HI};
	logic [7:0] exp_q [$];
	int failures = 0;
	int n_tests = 0;
	wire logic sda;
	// Open-drain line with pull-up
	assign sda = host_sda & (sda_oe_n | sda_drv);
	hri_top u_dut (.CLOCK_I(clk), .RSTN_I(rst_n), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(sda_drv), .SDA_OE_N_O(sda_oe_n),
		.SAMPLE_VALID_I(smp_v), .PLATE_A_I(pa), .PLATE_B_I(pb),
		.EVENT_O(evt));
	hri_host_model #(.DEV(I2C_ADDR_DFLT)) u_host (.clk_i(clk),
		.sda_i(sda), .scl_o(scl), .sda_o(host_sda), .rd_valid_o(rd_v),
		.rd_data_o(rd_d), .nack_o(nack));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("Compares %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.read(a);
	endtask : rd
	// Strobe one plate pair, then count events over the update time
	task automatic smp(input logic signed [PLATE_W-1:0] a,
		input logic signed [PLATE_W-1:0] b, input logic [15:0] ne);
		int n;
		n = 0;
		pa = a;
		pb = b;
		smp_v = 1'b1;
		@(posedge clk);
		#1;
		smp_v = 1'b0;
		repeat (160)
		begin
			@(posedge clk);
			#1;
			n += (evt === 1'b1);
		end
		check(16'(n), ne);
	endtask : smp
	always @(posedge clk)
		if (rd_v === 1'b1)
			check({8'h00, rd_d}, {8'h00, exp_q.pop_front()});
	initial
	begin
		repeat (80000) @(posedge clk);
		failures++;
		$display("Watchdog expired");
		end_of_test();
	end
	initial
	begin
		rst_n = 1'b0;
		smp_v = 1'b0;
		pa = '0;
		pb = '0;
		void'($urandom(39));
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		rd(ADDR_UI_SET, UI_SET_RST);
		rd(ADDR_COS_K, COS_K_RST);
		rd(ADDR_ISIZE, ISIZE_RST);
		rd(ADDR_FLAGS, 8'h00);
		rd(ADDR_IVAL, 8'h00);
		$display("Test reset values done");
		for (int i = 0; i < 3; i++)
		begin
			r = 8'($urandom);
			u_host.write(rw_a[i], r);
			rd(rw_a[i], r);
		end
		u_host.write(ADDR_OFS_HI, 8'h00);
		u_host.write(ADDR_SIN_K, 8'h00);
		u_host.write(ADDR_FILT_LO, 8'h5a);
		rd(ADDR_FILT_LO, 8'h00);
		u_host.write(8'h20, 8'h77);
		rd(8'h20, 8'h00);
		$display("Test register access done");
		u_host.write(ADDR_ISIZE, 8'h24);
		u_host.write(ADDR_SENS_SET, 8'h01);
		u_host.write(ADDR_BETA, 8'h00);
		u_host.write(ADDR_UI_SET, UI_SET_RST);
		smp(12'sh000, 12'sh3e8, 16'h0001);
		rd(ADDR_RAW_LO, 8'h5a);
		rd(ADDR_FILT_LO, 8'h5a);
		rd(ADDR_DELTA, 8'h5a);
		rd(ADDR_FLAGS, 8'hc0);
		rd(ADDR_IVAL, 8'h02);
		$display("Test forward step done");
		u_host.write(ADDR_DIR_SET, 8'h01);
		// Movement events on, interval events off
		u_host.write(ADDR_UI_SET, 8'h0c);
		smp(12'sh3e8, 12'sh000, 16'h0001);
		rd(ADDR_FLAGS, 8'hc1);
		rd(ADDR_DELTA, 8'h5a);
		rd(ADDR_IVAL, 8'h00);
		u_host.write(ADDR_DIR_SET, 8'h00);
		u_host.write(ADDR_UI_SET, UI_SET_RST);
		smp(12'sh000, 12'shc18, 16'h0001);
		rd(ADDR_RAW_LO, 8'h0e);
		rd(ADDR_RAW_HI, 8'h01);
		rd(ADDR_FLAGS, 8'h83);
		rd(ADDR_IVAL, 8'h07);
		$display("Test backward steps done");
		u_host.write(ADDR_UI_SET, 8'h34);
		rd(ADDR_UI_SET, 8'h14);
		rd(ADDR_FILT_LO, 8'h00);
		rd(ADDR_FILT_HI, 8'h00);
		rd(ADDR_RAW_HI, 8'h01);
		rd(ADDR_FLAGS, 8'h81);
		check({8'h00, nack}, 16'h0000);
		$display("Test zeroing done");
		end_of_test();
	end
endmodule : hall_rotation_angle_interval_ui_tb
`default_nettype wire
